/* File: acir_pkg.sv */
// Package: register map, field positions and constants of the converter control
package acir_pkg;
    localparam logic [15:0] ACIR_ADDR_PRESCALE = 16'hff13;
    localparam logic [15:0] ACIR_ADDR_PRIO = 16'hff22;
    localparam logic [15:0] ACIR_ADDR_ENABLE = 16'hff26;
    localparam logic [15:0] ACIR_ADDR_FLAG = 16'hff2a;
    localparam logic [15:0] ACIR_ADDR_IRQ_STATUS = 16'hff30;
    localparam logic [15:0] ACIR_ADDR_IRQ_MASK = 16'hff31;
    localparam logic [15:0] ACIR_ADDR_CPU_LEVEL = 16'hff32;
    localparam int ACIR_GATE_BIT = 3;
    localparam int ACIR_SEL_HI = 2;
    localparam int ACIR_SEL_LO = 0;
    localparam int ACIR_CONV_PRIO_HI = 7;
    localparam int ACIR_CONV_PRIO_LO = 6;
    localparam int ACIR_TOUCH_PRIO_HI = 5;
    localparam int ACIR_TOUCH_PRIO_LO = 4;
    localparam int ACIR_DONE_BIT = 7;
    localparam int ACIR_PEN_BIT = 6;
    localparam int ACIR_UPD_BIT = 5;
    localparam logic [7:0] ACIR_PRESCALE_MASK = 8'h0f;
    localparam logic [7:0] ACIR_PRIO_MASK = 8'hf0;
    localparam logic [7:0] ACIR_EVENT_MASK = 8'he0;
    localparam logic [7:0] ACIR_RESET_BYTE = 8'h00;
    localparam logic [1:0] ACIR_LEVEL_RESET = 2'h3;
    localparam logic [2:0] ACIR_SEL_DIV8 = 3'h3;
    localparam logic [2:0] ACIR_SEL_DIV4 = 3'h2;
    localparam logic [2:0] ACIR_SEL_DIV2 = 3'h1;
    localparam logic [2:0] ACIR_SEL_DIV1 = 3'h0;
    localparam int ACIR_DIV_WIDTH = 4;
    localparam int ACIR_NUM_EVENTS = 3;
endpackage

/* File: acir_divider.sv */
// Divider chain of the oscillator clock enable and rate selector
`timescale 1ns/1ps
module acir_divider
    import acir_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic osc_tick,
    input wire logic [2:0] sel,
    input wire logic gate,
    output logic conv_tick
);
    logic [ACIR_DIV_WIDTH-1:0] count;
    logic [ACIR_DIV_WIDTH:0] wrap;
    logic pick;

    // Each stage wraps when all lower bits are ones on a tick
    genvar i;
    generate
        for (i = 0; i <= ACIR_DIV_WIDTH; i++) begin : g_wrap
            if (i == 0) begin : g_first
                assign wrap[i] = osc_tick;
            end else begin : g_next
                assign wrap[i] = osc_tick && (&count[i-1:0]);
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (osc_tick) begin
            count <= count + ACIR_DIV_WIDTH'(1);
        end
    end

    always_comb begin
        if (sel[ACIR_SEL_HI]) begin
            pick = wrap[ACIR_DIV_WIDTH];
        end else begin
            case (sel[1:0])
                ACIR_SEL_DIV8[1:0]: pick = wrap[3];
                ACIR_SEL_DIV4[1:0]: pick = wrap[2];
                ACIR_SEL_DIV2[1:0]: pick = wrap[1];
                default: pick = wrap[0];
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            conv_tick <= 1'b0;
        end else begin
            conv_tick <= gate && pick;
        end
    end
endmodule

/* File: acir_control.sv */
// Converter clock, interrupt priority and enable control registers
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module acir_control
    import acir_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic high_speed_osc_clock,
    input wire logic conv_done,
    input wire logic pen_down,
    input wire logic touch_update,
    input wire logic [1:0] cpu_mask_level,
    output logic conv_clock_tick,
    output logic conv_irq_req,
    output logic [1:0] conv_irq_level,
    output logic touch_irq_req,
    output logic [1:0] touch_irq_level,
    output logic irq
);
    logic [7:0] prescale;
    logic [7:0] prio;
    logic [7:0] enable;
    logic [7:0] flags;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic osc_tick;
    logic div_tick;
    logic [7:0] events;
    logic [7:0] next_flags;
    logic [7:0] next_status;
    logic [7:0] next_mask;
    logic [7:0] read_value;
    logic conv_clock_gate;
    logic [2:0] conv_div_sel;
    logic [1:0] conv_prio;
    logic [1:0] touch_prio;
    logic conv_done_flag;
    logic conv_done_irq_enable;
    logic pen_down_irq_enable;
    logic touch_update_irq_enable;

    assign conv_clock_gate = prescale[ACIR_GATE_BIT];
    assign conv_div_sel = prescale[ACIR_SEL_HI:ACIR_SEL_LO];
    assign conv_prio = prio[ACIR_CONV_PRIO_HI:ACIR_CONV_PRIO_LO];
    assign touch_prio = prio[ACIR_TOUCH_PRIO_HI:ACIR_TOUCH_PRIO_LO];
    assign conv_done_flag = flags[ACIR_DONE_BIT];
    assign conv_done_irq_enable = enable[ACIR_DONE_BIT];
    assign pen_down_irq_enable = enable[ACIR_PEN_BIT];
    assign touch_update_irq_enable = enable[ACIR_UPD_BIT];

    // Oscillator clock is sampled; a rising edge counts once stages agree
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else begin
            osc_s1 <= high_speed_osc_clock;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    logic osc_level;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            osc_level <= 1'b0;
        end else if (osc_s2 == osc_s3) begin
            osc_level <= osc_s3;
        end
    end
    assign osc_tick = (osc_s2 == osc_s3) && osc_s3 && !osc_level;

    acir_divider u_div (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .osc_tick(osc_tick),
        .sel(conv_div_sel),
        .gate(conv_clock_gate),
        .conv_tick(div_tick)
    );

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            conv_clock_tick <= 1'b0;
        end else begin
            conv_clock_tick <= div_tick;
        end
    end

    // Prescaler control: only gate and select bits are stored
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prescale <= ACIR_RESET_BYTE;
        end else if (wr && addr == ACIR_ADDR_PRESCALE) begin
            prescale <= wdata & ACIR_PRESCALE_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prio <= ACIR_RESET_BYTE;
        end else if (wr && addr == ACIR_ADDR_PRIO) begin
            prio <= wdata & ACIR_PRIO_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            enable <= ACIR_RESET_BYTE;
        end else if (wr && addr == ACIR_ADDR_ENABLE) begin
            enable <= wdata & ACIR_EVENT_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_mask <= ACIR_RESET_BYTE;
        end else begin
            irq_mask <= next_mask;
        end
    end

    // The level output follows a mask write in the same cycle as the mask
    always_comb begin
        next_mask = irq_mask;
        if (wr && addr == ACIR_ADDR_IRQ_MASK) begin
            next_mask = wdata & ACIR_EVENT_MASK;
        end
    end

    always_comb begin
        events = ACIR_RESET_BYTE;
        events[ACIR_DONE_BIT] = conv_done;
        events[ACIR_PEN_BIT] = pen_down;
        events[ACIR_UPD_BIT] = touch_update;
    end

    // Factor flags: set regardless of enable, write one clears, set wins
    always_comb begin
        next_flags = flags;
        if (wr && addr == ACIR_ADDR_FLAG) begin
            next_flags = flags & ~(wdata & ACIR_EVENT_MASK);
        end
        next_flags = next_flags | events;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flags <= ACIR_RESET_BYTE;
        end else begin
            flags <= next_flags;
        end
    end

    // Sticky status cleared by a read, new events win
    always_comb begin
        next_status = irq_status;
        if (rd && addr == ACIR_ADDR_IRQ_STATUS) begin
            next_status = ACIR_RESET_BYTE;
        end
        next_status = next_status | events;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_status <= ACIR_RESET_BYTE;
        end else begin
            irq_status <= next_status;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & next_mask);
        end
    end

    // Requests to the CPU interrupt controller
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            conv_irq_req <= 1'b0;
            touch_irq_req <= 1'b0;
            conv_irq_level <= 2'h0;
            touch_irq_level <= 2'h0;
        end else begin
            conv_irq_req <= next_flags[ACIR_DONE_BIT]
                && conv_done_irq_enable
                && (conv_prio > cpu_mask_level);
            touch_irq_req <= ((next_flags[ACIR_PEN_BIT]
                && pen_down_irq_enable)
                || (next_flags[ACIR_UPD_BIT]
                && touch_update_irq_enable))
                && (touch_prio > cpu_mask_level);
            conv_irq_level <= conv_prio;
            touch_irq_level <= touch_prio;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        case (addr)
            ACIR_ADDR_PRESCALE: read_value = prescale;
            ACIR_ADDR_PRIO: read_value = prio;
            ACIR_ADDR_ENABLE: read_value = enable;
            ACIR_ADDR_FLAG: read_value = flags;
            ACIR_ADDR_IRQ_STATUS: read_value = irq_status;
            ACIR_ADDR_IRQ_MASK: read_value = irq_mask;
            default: read_value = ACIR_RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata <= ACIR_RESET_BYTE;
        end else if (rd) begin
            rdata <= read_value;
        end else begin
            rdata <= ACIR_RESET_BYTE;
        end
    end

    // Check helper: oscillator ticks between two divided ticks
    logic [4:0] osc_count;
    logic sel_steady;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            osc_count <= 5'h00;
        end else if (div_tick) begin
            osc_count <= {4'h0, osc_tick};
        end else if (osc_tick) begin
            osc_count <= osc_count + 5'h01;
        end
    end

    // A new rate is trusted only after its first divided tick, which may follow the write by less than a full divided period
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sel_steady <= 1'b0;
        end else if (wr && addr == ACIR_ADDR_PRESCALE) begin
            sel_steady <= 1'b0;
        end else if (div_tick) begin
            sel_steady <= 1'b1;
        end
    end

    a_gate_blocks: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        !conv_clock_gate |=> ##1 !conv_clock_tick)
        else $error("converter clock ran while gate off");
    a_prescale_wr: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        wr && addr == ACIR_ADDR_PRESCALE |=>
        prescale == ($past(wdata) & ACIR_PRESCALE_MASK))
        else $error("prescaler register did not take write");
    a_div8_spacing: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        conv_clock_tick && conv_div_sel == ACIR_SEL_DIV8 && conv_clock_gate
        && $stable(prescale) |=> !conv_clock_tick [*4])
        else $error("divide by eight ticks too close");
    a_div8_count: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        div_tick && sel_steady && conv_div_sel == ACIR_SEL_DIV8
        |-> osc_count == 5'h08)
        else $error("divide by eight period wrong");
    a_div4_count: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        div_tick && sel_steady && conv_div_sel == ACIR_SEL_DIV4
        |-> osc_count == 5'h04)
        else $error("divide by four period wrong");
    a_div16_count: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        div_tick && sel_steady && conv_div_sel[ACIR_SEL_HI]
        |-> osc_count == 5'h10)
        else $error("divide by sixteen period wrong");
    a_done_enable: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        !conv_done_irq_enable |=> !conv_irq_req)
        else $error("completion request while disabled");
    a_pen_enable: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        !pen_down_irq_enable && !touch_update_irq_enable |=> !touch_irq_req)
        else $error("touch request while disabled");
    a_touch_prio: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        touch_irq_req |-> $past(touch_prio) > $past(cpu_mask_level))
        else $error("touch request without priority");
    a_sel_reset: assert property (
        @(posedge clk_sys)
        !resetn |=> conv_div_sel == ACIR_SEL_DIV1 || resetn)
        else $error("division select not zero after reset");
    a_prio_gate: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        conv_irq_req |-> $past(conv_prio) > $past(cpu_mask_level)
        && $past(conv_done_irq_enable))
        else $error("completion request without priority");
    a_done_req: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        conv_done_flag && conv_done_irq_enable
        && conv_prio > cpu_mask_level && !(wr && addr == ACIR_ADDR_FLAG)
        |=> conv_irq_req)
        else $error("completion request missing");
    a_flag_set: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        conv_done |=> conv_done_flag)
        else $error("completion flag not set");
    a_flag_clear: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        wr && addr == ACIR_ADDR_FLAG && wdata[ACIR_DONE_BIT] && !conv_done
        |=> !conv_done_flag)
        else $error("completion flag not cleared by write one");
    a_pen_clear: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        wr && addr == ACIR_ADDR_FLAG && wdata[ACIR_PEN_BIT] && !pen_down
        |=> !flags[ACIR_PEN_BIT])
        else $error("pen-down flag not cleared by write one");
    a_unused_zero: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        rd && addr == ACIR_ADDR_ENABLE |=> rdata[4:0] == 5'h00)
        else $error("unused enable bits read nonzero");
    a_rdata_idle: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        !rd |=> rdata == ACIR_RESET_BYTE)
        else $error("read data not zero without a read");
    a_status_clear: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        rd && addr == ACIR_ADDR_IRQ_STATUS
        && !conv_done && !pen_down && !touch_update
        |=> irq_status == ACIR_RESET_BYTE)
        else $error("status not cleared by read");
    a_irq_level: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        irq == |(irq_status & irq_mask))
        else $error("interrupt level disagrees with status and mask");
endmodule

/* File: adc_clock_irq_control_regs_tb.sv */
// Self-checking bench for the converter clock and interrupt control block
`timescale 1ns/1ps
module adc_clock_irq_control_regs_tb;
    import acir_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [1:0] osc_phase = 2'h0;
    logic conv_done = 1'b0;
    logic pen_down = 1'b0;
    logic touch_update = 1'b0;
    logic [1:0] cpu_mask_level = 2'h1;
    logic conv_clock_tick, conv_irq_req, touch_irq_req, irq;
    logic [1:0] conv_irq_level, touch_irq_level;
    int n_errors = 0;
    int total_checks = 0;
    int ticks = 0;
    logic [7:0] got;

    acir_control u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata),
        .high_speed_osc_clock(osc_phase[1]), .conv_done(conv_done),
        .pen_down(pen_down), .touch_update(touch_update),
        .cpu_mask_level(cpu_mask_level), .conv_clock_tick(conv_clock_tick),
        .conv_irq_req(conv_irq_req), .conv_irq_level(conv_irq_level),
        .touch_irq_req(touch_irq_req), .touch_irq_level(touch_irq_level),
        .irq(irq)
    );

    always #12.5 clk_sys = ~clk_sys;

    // Oscillator at a quarter of the system clock, each level two cycles
    always @(posedge clk_sys) begin
        osc_phase <= osc_phase + 2'h1;
    end

    always @(posedge clk_sys) begin
        if (conv_clock_tick === 1'b1) begin
            ticks <= ticks + 1;
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic read_chk(input string what, input logic [15:0] a,
                            input logic [7:0] exp);
        logic [7:0] d;
        bus_read(a, d);
        chk(what, exp, d);
    endtask

    // One-cycle event pulse; the request is looked at one cycle later
    task automatic pulse(input int which);
        @(posedge clk_sys);
        if (which == 0) conv_done <= 1'b1;
        if (which == 1) pen_down <= 1'b1;
        if (which == 2) touch_update <= 1'b1;
        @(posedge clk_sys);
        conv_done <= 1'b0;
        pen_down <= 1'b0;
        touch_update <= 1'b0;
        #1;
    endtask

    task automatic settle;
        @(posedge clk_sys);
        #1;
    endtask

    // Counts converter ticks over 64 oscillator periods
    task automatic rate(input logic [7:0] ctrl, input int exp);
        int start;
        bus_write(ACIR_ADDR_PRESCALE, ctrl);
        repeat (10) @(posedge clk_sys);
        start = ticks;
        repeat (256) @(posedge clk_sys);
        total_checks++;
        if (ticks - start != exp) begin
            n_errors++;
            $display("unexpected tick count: expected %0d, seen %0d",
                     exp, ticks - start);
        end
    endtask

    task automatic results;
        $display("checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        n_errors++;
        results();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        read_chk("prescale reset", ACIR_ADDR_PRESCALE, 8'h00);
        read_chk("priority reset", ACIR_ADDR_PRIO, 8'h00);
        read_chk("enable reset", ACIR_ADDR_ENABLE, 8'h00);
        read_chk("flag reset", ACIR_ADDR_FLAG, 8'h00);
        read_chk("status reset", ACIR_ADDR_IRQ_STATUS, 8'h00);
        bus_write(ACIR_ADDR_PRESCALE, 8'hff);
        read_chk("prescale unused", ACIR_ADDR_PRESCALE, 8'h0f);
        bus_write(ACIR_ADDR_PRIO, 8'hff);
        read_chk("priority unused", ACIR_ADDR_PRIO, 8'hf0);
        bus_write(ACIR_ADDR_ENABLE, 8'h1f);
        read_chk("enable unused", ACIR_ADDR_ENABLE, 8'h00);
        bus_write(16'hff40, 8'hff);
        read_chk("unmapped read", 16'hff40, 8'h00);
        rate(8'h03, 0);
        for (int s = 0; s < 8; s++) begin
            rate({5'h01, s[2:0]}, s[2] ? 4 : 64 >> s);
        end
        bus_write(ACIR_ADDR_PRIO, 8'h80);
        pulse(0);
        chk("done req disabled", 8'h00, {7'h0, conv_irq_req});
        read_chk("flag without enable", ACIR_ADDR_FLAG, 8'h80);
        bus_write(ACIR_ADDR_ENABLE, 8'h80);
        settle();
        chk("done req enabled", 8'h01, {7'h0, conv_irq_req});
        chk("conv level", 8'h02, {6'h0, conv_irq_level});
        @(posedge clk_sys);
        cpu_mask_level <= 2'h2;
        settle();
        settle();
        chk("done req at mask", 8'h00, {7'h0, conv_irq_req});
        @(posedge clk_sys);
        cpu_mask_level <= 2'h1;
        bus_write(ACIR_ADDR_FLAG, 8'h00);
        read_chk("flag kept", ACIR_ADDR_FLAG, 8'h80);
        bus_write(ACIR_ADDR_FLAG, 8'h80);
        read_chk("flag cleared", ACIR_ADDR_FLAG, 8'h00);
        chk("done req cleared", 8'h00, {7'h0, conv_irq_req});
        bus_write(ACIR_ADDR_PRIO, 8'hb0);
        bus_write(ACIR_ADDR_ENABLE, 8'h40);
        pulse(1);
        chk("pen req", 8'h01, {7'h0, touch_irq_req});
        chk("touch level", 8'h03, {6'h0, touch_irq_level});
        bus_write(ACIR_ADDR_FLAG, 8'h40);
        settle();
        chk("pen req cleared", 8'h00, {7'h0, touch_irq_req});
        pulse(2);
        chk("update req off", 8'h00, {7'h0, touch_irq_req});
        bus_write(ACIR_ADDR_ENABLE, 8'h20);
        settle();
        chk("update req on", 8'h01, {7'h0, touch_irq_req});
        chk("irq masked", 8'h00, {7'h0, irq});
        bus_write(ACIR_ADDR_IRQ_MASK, 8'he0);
        settle();
        chk("irq unmasked", 8'h01, {7'h0, irq});
        read_chk("status", ACIR_ADDR_IRQ_STATUS, 8'he0);
        settle();
        chk("irq after read", 8'h00, {7'h0, irq});
        read_chk("status cleared", ACIR_ADDR_IRQ_STATUS, 8'h00);
        results();
    end
endmodule
